/* File: pccn_defs.svh */
`ifndef PCCN_DEFS_SVH
`define PCCN_DEFS_SVH

// Payload geometry
`define PCCN_PAYLOAD_BYTES 6
`define PCCN_CHAN_MIN 8'h01
`define PCCN_CHAN_MAX 8'h1e
`define PCCN_SPEED_MAX 4'h8

// Frame-format byte fields
`define PCCN_FMT_LEN_LSB 0
`define PCCN_FMT_STOP_BIT 2
`define PCCN_FMT_PAR_EN_BIT 3
`define PCCN_FMT_PAR_KIND_LSB 4

// Handshake-options byte fields
`define PCCN_HS_PAUSE_RX_BIT 0
`define PCCN_HS_PAUSE_TX_BIT 1
`define PCCN_HS_RTR_IN_BIT 2
`define PCCN_HS_RTR_OUT_BIT 3
`define PCCN_HS_RTC_IN_BIT 4
`define PCCN_HS_RTC_OUT_BIT 5

// Framing defaults, arbitrary values
`define PCCN_DEF_START 8'h02
`define PCCN_DEF_TYPE 8'h69
`define PCCN_DEF_OPCODE 8'h3e
`define PCCN_DEF_END 8'h03

`endif

/* File: pccn_pkg.sv */
package pccn_pkg;

    // Character length codes
    typedef enum logic [1:0] {
        PCCN_LEN5, PCCN_LEN6, PCCN_LEN7, PCCN_LEN8
    } pccn_len_type;

    // Check-bit kinds
    typedef enum logic [1:0] {
        PCCN_ODD, PCCN_EVEN, PCCN_MARK, PCCN_SPACE
    } pccn_par_type;

    // Settings changed by the remote peer
    typedef struct packed {
        logic [7:0] local_channel_number;
        logic [3:0] speed_code;
        pccn_len_type char_len;
        logic stop_one_and_half;
        logic check_bit_used;
        pccn_par_type check_bit_kind;
        logic inband_pause_on_receive;
        logic inband_pause_on_transmit;
        logic ready_receive_line_on_input;
        logic ready_receive_line_on_output;
        logic ready_comm_line_on_input;
        logic ready_comm_line_on_output;
        logic [7:0] resume_character;
        logic [7:0] pause_character;
    } pccn_cfg_type;

    // Byte stream toward the host
    typedef struct packed {
        logic valid;
        logic first;
        logic last;
        logic [7:0] data;
    } pccn_byte_type;

endpackage

/* File: pccn_framer.sv */
`timescale 1ns/1ns
`include "pccn_defs.svh"
// How it works
// RULE1: Remote settings change triggers unsolicited notice
// RULE2: Six payload bytes, channel 1 to 30
// RULE3: Byte two is speed code 0 to 8
// RULE4: Format bits 1:0 give character length
// RULE5: Format bit 2 selects stop length
// RULE6: Format bit 3 flags parity present
// RULE7: Format bits 5:4 give parity kind
// RULE8: Reserved bits 7:6 sent as zero
// RULE9: Handshake bits 0,1 in-band pause rx/tx
// RULE10: Handshake bits 2,3 ready-receive line in/out
// RULE11: Handshake bits 4,5 ready-comm line in/out
// RULE12: Fifth byte is resume character
// RULE13: Sixth byte is pause character
// RULE14: Line conditions relayed while link active
// RULE15: Relayed line notices never touch flow control
// RULE16: Framing codes are parameters
module pccn_framer
    import pccn_pkg::*;
#(
    parameter logic [7:0] START_CODE = `PCCN_DEF_START,
    parameter logic [7:0] TYPE_CODE = `PCCN_DEF_TYPE,
    parameter logic [7:0] OPCODE = `PCCN_DEF_OPCODE,
    parameter logic [7:0] END_CODE = `PCCN_DEF_END,
    parameter int PAYLOAD_BYTES = `PCCN_PAYLOAD_BYTES
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic link_active,
    input wire logic cfg_change,
    input wire pccn_cfg_type cfg_in,
    input wire logic [7:0] line_state_in,
    input wire logic line_state_change,
    input wire logic out_ready,
    output pccn_byte_type out_q,
    output logic busy_q,
    output logic cfg_rejected_q,
    output logic [7:0] remote_line_state_q,
    output logic line_state_event_q
);

    ////////////////////////////////////////////////////////////////////
    // Elaboration checks: length byte and index are sized for six
    if (PAYLOAD_BYTES != `PCCN_PAYLOAD_BYTES) begin : g_bad_payload
        $error("payload must be six bytes");
    end
    if (PAYLOAD_BYTES > 8) begin : g_bad_index
        $error("payload index is three bits wide");
    end

    typedef enum logic [2:0] {
        S_IDLE, S_START, S_TYPE, S_OPC, S_LEN, S_DATA, S_END
    } pccn_state_type;

    pccn_state_type state_q, state_d;
    pccn_cfg_type cfg_q;
    logic [2:0] idx_q, idx_d;
    logic pend_q;
    pccn_cfg_type pend_cfg_q; // Latest accepted, waiting for idle

    ////////////////////////////////////////////////////////////////////
    // Validity of incoming settings
    wire chan_ok = cfg_in.local_channel_number >= `PCCN_CHAN_MIN &&
        cfg_in.local_channel_number <= `PCCN_CHAN_MAX; // RULE2
    wire speed_ok = cfg_in.speed_code <= `PCCN_SPEED_MAX; // RULE3
    wire accept = cfg_change && link_active && chan_ok && speed_ok; // RULE1
    // A refused change is flagged for one cycle, nothing is queued
    wire reject = cfg_change && !accept;

    // Frame-format byte; bits 7:6 stay zero as reserved
    logic [7:0] fmt_byte;
    always_comb begin
        fmt_byte = 8'h00; // RULE8
        fmt_byte[`PCCN_FMT_LEN_LSB +: 2] = cfg_q.char_len; // RULE4
        fmt_byte[`PCCN_FMT_STOP_BIT] = cfg_q.stop_one_and_half; // RULE5
        fmt_byte[`PCCN_FMT_PAR_EN_BIT] = cfg_q.check_bit_used; // RULE6
        fmt_byte[`PCCN_FMT_PAR_KIND_LSB +: 2] = cfg_q.check_bit_kind; // RULE7
    end

    // Handshake-options byte; bits 7:6 stay zero as reserved
    logic [7:0] hs_byte;
    always_comb begin
        hs_byte = 8'h00; // RULE8
        hs_byte[`PCCN_HS_PAUSE_RX_BIT] =
            cfg_q.inband_pause_on_receive; // RULE9
        hs_byte[`PCCN_HS_PAUSE_TX_BIT] =
            cfg_q.inband_pause_on_transmit; // RULE9
        hs_byte[`PCCN_HS_RTR_IN_BIT] =
            cfg_q.ready_receive_line_on_input; // RULE10
        hs_byte[`PCCN_HS_RTR_OUT_BIT] =
            cfg_q.ready_receive_line_on_output; // RULE10
        hs_byte[`PCCN_HS_RTC_IN_BIT] =
            cfg_q.ready_comm_line_on_input; // RULE11
        hs_byte[`PCCN_HS_RTC_OUT_BIT] =
            cfg_q.ready_comm_line_on_output; // RULE11
    end

    // Payload byte for the index about to be shown
    logic [7:0] pay_byte_next;
    always_comb begin
        case (idx_d)
            3'd0: pay_byte_next = cfg_q.local_channel_number; // RULE2
            3'd1: pay_byte_next = {4'h0, cfg_q.speed_code}; // RULE3
            3'd2: pay_byte_next = fmt_byte;
            3'd3: pay_byte_next = hs_byte;
            3'd4: pay_byte_next = cfg_q.resume_character; // RULE12
            3'd5: pay_byte_next = cfg_q.pause_character; // RULE13
            default: pay_byte_next = 8'h00;
        endcase
    end

    // Frame sequencing, leaves idle on a pending notice, then advances when the host side takes a byte
    wire take = out_q.valid && out_ready;
    wire [7:0] len_byte = 8'(PAYLOAD_BYTES);
    always_comb begin
        state_d = state_q;
        idx_d = idx_q;
        case (state_q)
            S_IDLE: begin
                if (pend_q)
                    state_d = S_START;
            end
            S_START: begin
                if (take)
                    state_d = S_TYPE;
            end
            S_TYPE: begin
                if (take)
                    state_d = S_OPC;
            end
            S_OPC: begin
                if (take)
                    state_d = S_LEN;
            end
            S_LEN: begin
                if (take) begin
                    state_d = S_DATA;
                    idx_d = 3'd0;
                end
            end
            S_DATA: begin
                if (take) begin
                    if (idx_q == 3'(PAYLOAD_BYTES - 1))
                        state_d = S_END;
                    else
                        idx_d = idx_q + 3'd1;
                end
            end
            S_END: begin
                if (take)
                    state_d = S_IDLE;
            end
            default: state_d = S_IDLE;
        endcase
    end

    // Byte presented in the next state
    pccn_byte_type out_d;
    always_comb begin
        out_d = '0;
        out_d.valid = state_d != S_IDLE;
        out_d.first = state_d == S_START;
        out_d.last = state_d == S_END;
        case (state_d)
            S_START: out_d.data = START_CODE; // RULE16
            S_TYPE: out_d.data = TYPE_CODE; // RULE16
            S_OPC: out_d.data = OPCODE; // RULE16
            S_LEN: out_d.data = len_byte; // RULE2
            S_DATA: out_d.data = pay_byte_next;
            S_END: out_d.data = END_CODE; // RULE16
            default: out_d.data = 8'h00;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // Settings capture; a change during a frame waits in a holding
    // copy, so the bytes of the frame in flight never move
    wire load = pend_q && state_q == S_IDLE;
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            pend_cfg_q <= '0;
            cfg_q <= '0;
            pend_q <= 1'b0;
        end else begin
            if (accept)
                pend_cfg_q <= cfg_in; // RULE1
            if (load)
                cfg_q <= pend_cfg_q; // RULE1
            // A change in the load cycle queues one more notice
            pend_q <= accept || (pend_q && !load); // RULE1
        end
    end

    // Sequencer registers
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            state_q <= S_IDLE;
            idx_q <= 3'd0;
            out_q <= '0;
            busy_q <= 1'b0;
            cfg_rejected_q <= 1'b0;
        end else begin
            state_q <= state_d;
            idx_q <= idx_d;
            out_q <= out_d;
            busy_q <= state_d != S_IDLE;
            cfg_rejected_q <= reject;
        end
    end

    // Line conditions relayed to the host only, no flow-control effect
    // The relay never reaches the sequencer or the pending flag
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            remote_line_state_q <= 8'h00;
            line_state_event_q <= 1'b0;
        end else begin
            line_state_event_q <= line_state_change && link_active; // RULE14
            if (line_state_change && link_active)
                remote_line_state_q <= line_state_in; // RULE14 RULE15
        end
    end

endmodule

/* File: pccn_host_model.sv */
`timescale 1ns/1ns
module pccn_host_model
    import pccn_pkg::*;
(
    input wire logic sys_clk,
    input wire pccn_byte_type out_q,
    input wire logic slow,
    output logic out_ready
);
    logic [7:0] rx_q [$];
    int seed = 32'h93da2415;
    // Ready moves after the falling edge, stalls at random when slow
    always @(negedge sys_clk) begin
        out_ready <= !slow || $random(seed) % 2 == 0;
    end
    // Keeps each byte as sent, reserved bits left for decode
    always @(posedge sys_clk) begin
        if (out_q.valid && out_ready) begin
            rx_q.push_back(out_q.data);
        end
    end
endmodule

/* File: pccn_framer_sva.sv */
`timescale 1ns/1ns
module pccn_framer_sva
    import pccn_pkg::*;
#(
    parameter logic [7:0] START_CODE = 8'h02,
    parameter logic [7:0] END_CODE = 8'h03
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic link_active,
    input wire logic cfg_change,
    input wire pccn_cfg_type cfg_in,
    input wire logic [7:0] line_state_in,
    input wire logic line_state_change,
    input wire logic out_ready,
    input wire pccn_byte_type out_q,
    input wire logic busy_q,
    input wire logic cfg_rejected_q,
    input wire logic [7:0] remote_line_state_q,
    input wire logic line_state_event_q
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    logic [3:0] pos_q;
    wire logic ok = link_active && cfg_in.speed_code <= 4'h8
        && cfg_in.local_channel_number inside {[8'h01:8'h1e]};
    wire logic take = out_q.valid && out_ready;
    // Byte position within the frame
    always_ff @(posedge sys_clk) begin
        if (!resetn || (take && out_q.last)) pos_q <= 4'h0;
        else if (take) pos_q <= pos_q + 4'h1;
    end
    ////////////////////////////////////////////////////////////////////
    chk_refused_flag: assert property (
        cfg_change && !ok |=> cfg_rejected_q)
        else $error("refused change not flagged");
    chk_frame_start: assert property (cfg_change && ok && !busy_q
        && !$past(busy_q) && !$past(cfg_change)
        |=> ##1 out_q.valid && out_q.first
        && out_q.data == START_CODE) else $error("notice start late");
    chk_hold_byte: assert property (out_q.valid && !out_ready
        |=> $stable(out_q)) else $error("byte moved while stalled");
    chk_length_byte: assert property (out_q.valid && pos_q == 4'h3
        |-> out_q.data == 8'h06) else $error("length byte wrong");
    chk_channel_range: assert property (out_q.valid && pos_q == 4'h4
        |-> out_q.data inside {[8'h01:8'h1e]}) else $error("bad channel");
    chk_speed_code: assert property (out_q.valid && pos_q == 4'h5
        |-> out_q.data <= 8'h08) else $error("bad speed code");
    chk_reserved_zero: assert property (
        out_q.valid && pos_q[3:1] == 3'h3
        |-> out_q.data[7:6] == 2'b00) else $error("reserved bits set");
    chk_end_last: assert property (out_q.valid && out_q.last
        |-> pos_q == 4'ha && out_q.data == END_CODE) else $error("bad end");
    chk_line_relay: assert property (line_state_change && link_active
        |=> line_state_event_q && remote_line_state_q == $past(line_state_in))
        else $error("line status not relayed");
    chk_no_flow: assert property (
        line_state_change && !cfg_change && !busy_q && !$past(busy_q)
        && !$past(cfg_change) |=> !out_q.valid)
        else $error("line made a frame");
    cover property (cfg_rejected_q);
    cover property (take && out_q.last);
    cover property (out_q.valid && !out_ready);
endmodule
bind pccn_framer pccn_framer_sva #(.START_CODE(START_CODE),
    .END_CODE(END_CODE)) pccn_framer_sva_inst (.sys_clk(sys_clk),
    .resetn(resetn), .link_active(link_active), .cfg_change(cfg_change),
    .cfg_in(cfg_in), .line_state_in(line_state_in),
    .line_state_change(line_state_change), .out_ready(out_ready),
    .out_q(out_q), .busy_q(busy_q), .cfg_rejected_q(cfg_rejected_q),
    .remote_line_state_q(remote_line_state_q),
    .line_state_event_q(line_state_event_q));

/* File: port_config_change_notice_bench.sv */
`timescale 1ns/1ns
`include "pccn_defs.svh"
module port_config_change_notice_bench
    import pccn_pkg::*;
;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic link_active = 1'b1;
    logic cfg_change = 1'b0;
    logic line_state_change = 1'b0;
    logic slow = 1'b0;
    logic [7:0] line_state_in = 8'h00;
    pccn_cfg_type cfg_in = '0;
    pccn_cfg_type a, b;
    pccn_byte_type out_q;
    logic out_ready, busy_q, cfg_rejected_q, line_state_event_q;
    logic [7:0] remote_line_state_q;
    int mismatches = 0;
    int comparisons = 0;
    int seed = 32'h93da2415;
    always #5 sys_clk = !sys_clk;
    pccn_framer pccn_framer_inst (.sys_clk(sys_clk), .resetn(resetn),
        .link_active(link_active), .cfg_change(cfg_change), .cfg_in(cfg_in),
        .line_state_in(line_state_in), .line_state_change(line_state_change),
        .out_ready(out_ready), .out_q(out_q), .busy_q(busy_q),
        .cfg_rejected_q(cfg_rejected_q),
        .line_state_event_q(line_state_event_q),
        .remote_line_state_q(remote_line_state_q));
    pccn_host_model pccn_host_model_inst (.sys_clk(sys_clk), .out_q(out_q),
        .slow(slow), .out_ready(out_ready));
    ////////////////////////////////////////////////////////////////////
    task automatic cmp(input string what, input logic [7:0] exp, got);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // Random settings in range, codes stepped by n
    function automatic pccn_cfg_type rnd(input int n);
        pccn_cfg_type c;
        c = pccn_cfg_type'(40'({$random(seed), $random(seed)}));
        c.local_channel_number = n < 2 ? (n ? 8'h1e : 8'h01)
            : 8'({$random(seed)} % 30 + 1);
        c.speed_code = 4'(n % 9);
        c.char_len = pccn_len_type'(n[1:0]);
        c.check_bit_kind = pccn_par_type'(n[3:2]);
        return c;
    endfunction
    function automatic logic [7:0] hs(input pccn_cfg_type c);
        return {2'b00, c.ready_comm_line_on_output,
            c.ready_comm_line_on_input, c.ready_receive_line_on_output,
            c.ready_receive_line_on_input, c.inband_pause_on_transmit,
            c.inband_pause_on_receive};
    endfunction
    // One change pulse, then the refusal flag
    task automatic send(input pccn_cfg_type c, input logic rej);
        cfg_in = c;
        cfg_change = 1'b1;
        @(negedge sys_clk);
        cfg_change = 1'b0;
        cmp("refused", {7'h0, rej}, {7'h0, cfg_rejected_q});
    endtask
    // Waits for a whole notice at the host and checks it
    task automatic frame(input pccn_cfg_type c);
        logic [7:0] r [11];
        for (int k = 0; k < 300 && pccn_host_model_inst.rx_q.size() < 11; k++)
            @(negedge sys_clk);
        if (pccn_host_model_inst.rx_q.size() < 11) begin
            mismatches++;
            complete_run();
        end
        foreach (r[k]) r[k] = pccn_host_model_inst.rx_q.pop_front();
        cmp("start", `PCCN_DEF_START, r[0]);
        cmp("type", `PCCN_DEF_TYPE, r[1]);
        cmp("opcode", `PCCN_DEF_OPCODE, r[2]);
        cmp("length", 8'h06, r[3]);
        cmp("channel", c.local_channel_number, r[4]);
        cmp("speed", {4'h0, c.speed_code}, r[5]);
        cmp("format", {2'b00, c.check_bit_kind, c.check_bit_used,
            c.stop_one_and_half, c.char_len}, r[6]);
        cmp("handshake", hs(c), r[7]);
        cmp("resume", c.resume_character, r[8]);
        cmp("pause", c.pause_character, r[9]);
        cmp("end", `PCCN_DEF_END, r[10]);
    endtask
    initial begin
        repeat (8) @(posedge sys_clk);
        @(negedge sys_clk);
        resetn = 1'b1;
        // Every speed, length and check kind, host fast and slow
        for (int n = 0; n < 18; n++) begin
            slow = n[0];
            a = rnd(n);
            send(a, 1'b0);
            frame(a);
        end
        // Channel 0 and 31, speed 9, link down: no notice
        for (int n = 0; n < 4; n++) begin
            a = rnd(5);
            if (n == 0) a.local_channel_number = 8'h00;
            if (n == 1) a.local_channel_number = 8'h1f;
            if (n == 2) a.speed_code = 4'h9;
            link_active = n != 3;
            send(a, 1'b1);
            repeat (4) @(negedge sys_clk);
            cmp("count", 8'h00, 8'(pccn_host_model_inst.rx_q.size()));
        end
        link_active = 1'b1;
        // Two changes during a notice: only the latest follows
        a = rnd(7);
        b = rnd(11);
        send(a, 1'b0);
        repeat (3) @(negedge sys_clk);
        send(rnd(3), 1'b0);
        @(negedge sys_clk);
        send(b, 1'b0);
        frame(a);
        frame(b);
        cmp("count", 8'h00, 8'(pccn_host_model_inst.rx_q.size()));
        // Line status relay, no notice or flow effect
        for (int n = 0; n < 4; n++) begin
            line_state_in = 8'($random(seed));
            line_state_change = 1'b1;
            @(negedge sys_clk);
            line_state_change = 1'b0;
            cmp("event", 8'h01, {7'h0, line_state_event_q});
            cmp("status", line_state_in, remote_line_state_q);
            cmp("busy", 8'h00, {7'h0, busy_q});
        end
        complete_run();
    end
endmodule
